// ===== logic/half_rate_toggle.sv
// halves one divider output; idles low while the divider is bypassed
`timescale 1ns/1ps
`default_nettype none
module half_rate_toggle
	import status_mux_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic dividerPulse,
	input  wire logic bypassed,
	output logic      halfOut
);
	typedef struct packed {
		logic q;
	} toggle_state_t;

	toggle_state_t st;
	toggle_state_t next_st;

	always_comb begin
		next_st = st;
		if (bypassed) begin
			next_st.q = 1'b0;
		end else if (dividerPulse) begin
			next_st.q = ~st.q;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign halfOut = st.q;
endmodule
`default_nettype wire

// ===== logic/pin_driver.sv
// selects one source for a status pin, applies override and polarity
`timescale 1ns/1ps
`default_nettype none
module pin_driver
	import status_mux_pkg::*;
(
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic [NUM_SRC-1:0]   sources,
	input  wire logic [3:0]           sourceSelect,
	input  wire logic                 polarity,
	input  wire logic                 testActive,
	input  wire logic                 testLevel,
	output logic                      pinOut
);
	typedef struct packed {
		logic pin;
	} pin_state_t;

	pin_state_t st;
	pin_state_t next_st;

	always_comb begin
		next_st = st;
		if (testActive) begin
			next_st.pin = testLevel;
		end else begin
			next_st.pin = sources[sourceSelect] ~^ polarity;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign pinOut = st.pin;
endmodule
`default_nettype wire

// ===== logic/status_mux_pkg.sv
// constants for the status pin source selection block
package status_mux_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// byte addresses of the two configuration registers
	localparam logic [7:0] FIRST_CFG_ADDR  = 8'h1b;
	localparam logic [7:0] SECOND_CFG_ADDR = 8'h1c;
	// field layout
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 4;
	localparam int POL_BIT = 3;
	localparam logic [7:0] WRITABLE_MASK = 8'hf8;
	// reset values
	localparam logic [3:0] FIRST_SEL_RESET  = 4'h5;
	localparam logic [3:0] SECOND_SEL_RESET = 4'h2;
	localparam logic       POL_RESET        = 1'b1;
	// source codes
	localparam logic [3:0] SRC_PRI_LOS   = 4'h0;
	localparam logic [3:0] SRC_SEC_LOS   = 4'h1;
	localparam logic [3:0] SRC_S1_LOL    = 4'h2;
	localparam logic [3:0] SRC_S1_RDIV   = 4'h3;
	localparam logic [3:0] SRC_S1_NDIV   = 4'h4;
	localparam logic [3:0] SRC_S2_LOL    = 4'h5;
	localparam logic [3:0] SRC_S2_RDIV   = 4'h6;
	localparam logic [3:0] SRC_S2_NDIV   = 4'h7;
	localparam logic [3:0] SRC_S1_CAL    = 4'h8;
	localparam logic [3:0] SRC_S2_CAL    = 4'h9;
	localparam logic [3:0] SRC_INTERRUPT = 4'ha;
	localparam logic [3:0] SRC_S1_MDIV   = 4'hb;
	localparam logic [3:0] SRC_S2_MDIV   = 4'hc;
	localparam logic [3:0] SRC_NVM       = 4'hd;
	localparam logic [3:0] SRC_S1_SWITCH = 4'he;
	localparam logic [3:0] SRC_S2_SWITCH = 4'hf;
	localparam int NUM_SRC = 16;
	localparam int NUM_FLAGS = 8;
	typedef enum logic [1:0] {
		CFG_IDLE,
		CFG_NVM_LOAD,
		CFG_RUN
	} cfg_state_t;
endpackage

// ===== logic/status_pin_source_mux.sv
// status pin source selection with its two configuration registers
`timescale 1ns/1ps
`default_nettype none
module status_pin_source_mux
	import status_mux_pkg::*;
(
	input  wire logic                  ref_clk,
	input  wire logic                  arst_n,
	input  wire logic [ADDR_W-1:0]     regAddr,
	input  wire logic [DATA_W-1:0]     regWdata,
	input  wire logic                  regWrite,
	input  wire logic                  regRead,
	output logic      [DATA_W-1:0]     regRdata,
	input  wire logic                  nvmLoad,
	input  wire logic [DATA_W-1:0]     nvmFirstCfg,
	input  wire logic [DATA_W-1:0]     nvmSecondCfg,
	input  wire logic                  primaryRefLos,
	input  wire logic                  secondaryRefLos,
	input  wire logic                  synthOneLol,
	input  wire logic                  synthTwoLol,
	input  wire logic                  synthOneRdivPulse,
	input  wire logic                  synthTwoRdivPulse,
	input  wire logic                  synthOneRdivBypass,
	input  wire logic                  synthTwoRdivBypass,
	input  wire logic                  synthOneNdivPulse,
	input  wire logic                  synthTwoNdivPulse,
	input  wire logic                  synthOneMdivPulse,
	input  wire logic                  synthTwoMdivPulse,
	input  wire logic                  synthOneMdivBypass,
	input  wire logic                  synthTwoMdivBypass,
	input  wire logic                  synthOneCal,
	input  wire logic                  synthTwoCal,
	input  wire logic                  nvmActive,
	input  wire logic [NUM_FLAGS-1:0]  interruptFlags,
	input  wire logic [NUM_FLAGS-1:0]  interruptMask,
	input  wire logic                  synthOneAutoSwitch,
	input  wire logic                  synthTwoAutoSwitch,
	input  wire logic                  testFirstActive,
	input  wire logic                  testFirstLevel,
	input  wire logic                  testSecondActive,
	input  wire logic                  testSecondLevel,
	output logic                       first_indicator_pin,
	output logic                       second_indicator_pin
);
	typedef struct packed {
		cfg_state_t       mode;
		logic [3:0]       firstSel;
		logic             firstPol;
		logic [3:0]       secondSel;
		logic             secondPol;
		logic [DATA_W-1:0] rdata;
	} mux_state_t;

	mux_state_t st;
	mux_state_t next_st;

	logic [NUM_SRC-1:0] sources;
	logic s1RdivHalf;
	logic s2RdivHalf;
	logic s1NdivHalf;
	logic s2NdivHalf;
	logic s1MdivHalf;
	logic s2MdivHalf;
	logic combinedInterrupt;

	half_rate_toggle u_s1Rdiv (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.dividerPulse (synthOneRdivPulse),
		.bypassed     (synthOneRdivBypass),
		.halfOut      (s1RdivHalf)
	);
	half_rate_toggle u_s2Rdiv (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.dividerPulse (synthTwoRdivPulse),
		.bypassed     (synthTwoRdivBypass),
		.halfOut      (s2RdivHalf)
	);
	half_rate_toggle u_s1Ndiv (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.dividerPulse (synthOneNdivPulse),
		.bypassed     (1'b0),
		.halfOut      (s1NdivHalf)
	);
	half_rate_toggle u_s2Ndiv (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.dividerPulse (synthTwoNdivPulse),
		.bypassed     (1'b0),
		.halfOut      (s2NdivHalf)
	);
	half_rate_toggle u_s1Mdiv (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.dividerPulse (synthOneMdivPulse),
		.bypassed     (synthOneMdivBypass),
		.halfOut      (s1MdivHalf)
	);
	half_rate_toggle u_s2Mdiv (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.dividerPulse (synthTwoMdivPulse),
		.bypassed     (synthTwoMdivBypass),
		.halfOut      (s2MdivHalf)
	);

	assign combinedInterrupt = |(interruptFlags & interruptMask);

	always_comb begin
		sources                = '0;
		sources[SRC_PRI_LOS]   = primaryRefLos;
		sources[SRC_SEC_LOS]   = secondaryRefLos;
		sources[SRC_S1_LOL]    = synthOneLol;
		sources[SRC_S2_LOL]    = synthTwoLol;
		sources[SRC_S1_RDIV]   = s1RdivHalf;
		sources[SRC_S1_NDIV]   = s1NdivHalf;
		sources[SRC_S2_RDIV]   = s2RdivHalf;
		sources[SRC_S2_NDIV]   = s2NdivHalf;
		sources[SRC_S1_CAL]    = synthOneCal;
		sources[SRC_S2_CAL]    = synthTwoCal;
		sources[SRC_NVM]       = nvmActive;
		sources[SRC_INTERRUPT] = combinedInterrupt;
		sources[SRC_S1_MDIV]   = s1MdivHalf;
		sources[SRC_S2_MDIV]   = s2MdivHalf;
		sources[SRC_S1_SWITCH] = synthOneAutoSwitch;
		sources[SRC_S2_SWITCH] = synthTwoAutoSwitch;
	end

	pin_driver u_firstPin (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.sources      (sources),
		.sourceSelect (st.firstSel),
		.polarity     (st.firstPol),
		.testActive   (testFirstActive),
		.testLevel    (testFirstLevel),
		.pinOut       (first_indicator_pin)
	);
	pin_driver u_secondPin (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.sources      (sources),
		.sourceSelect (st.secondSel),
		.polarity     (st.secondPol),
		.testActive   (testSecondActive),
		.testLevel    (testSecondLevel),
		.pinOut       (second_indicator_pin)
	);

	always_comb begin
		next_st = st;
		next_st.rdata = '0;
		case (st.mode)
			CFG_IDLE: begin
				next_st.mode = CFG_RUN;
			end
			CFG_NVM_LOAD: begin
				// only select and polarity come from memory
				next_st.firstSel  = nvmFirstCfg[SEL_MSB:SEL_LSB];
				next_st.firstPol  = nvmFirstCfg[POL_BIT];
				next_st.secondSel = nvmSecondCfg[SEL_MSB:SEL_LSB];
				next_st.secondPol = nvmSecondCfg[POL_BIT];
				next_st.mode      = CFG_RUN;
			end
			CFG_RUN: begin
				if (nvmLoad) begin
					next_st.mode = CFG_NVM_LOAD;
				end
			end
			default: begin
				next_st.mode = CFG_IDLE;
			end
		endcase
		if (regWrite && st.mode != CFG_NVM_LOAD) begin
			// reserved bits are simply not stored
			if (regAddr == FIRST_CFG_ADDR) begin
				next_st.firstSel = regWdata[SEL_MSB:SEL_LSB];
				next_st.firstPol = regWdata[POL_BIT];
			end else if (regAddr == SECOND_CFG_ADDR) begin
				next_st.secondSel = regWdata[SEL_MSB:SEL_LSB];
				next_st.secondPol = regWdata[POL_BIT];
			end
		end
		if (regRead) begin
			if (regAddr == FIRST_CFG_ADDR) begin
				next_st.rdata = {st.firstSel, st.firstPol, 3'h0};
			end else if (regAddr == SECOND_CFG_ADDR) begin
				next_st.rdata = {st.secondSel, st.secondPol, 3'h0};
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st.mode      <= CFG_IDLE;
			st.firstSel  <= FIRST_SEL_RESET;
			st.firstPol  <= POL_RESET;
			st.secondSel <= SECOND_SEL_RESET;
			st.secondPol <= POL_RESET;
			st.rdata     <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign regRdata = st.rdata;

	property p_first_select_write;
		@(posedge ref_clk) disable iff (!arst_n)
		(regWrite && regAddr == FIRST_CFG_ADDR && st.mode == CFG_RUN)
			|=> st.firstSel == $past(regWdata[SEL_MSB:SEL_LSB]);
	endproperty
	a_first_select_write: assert property (p_first_select_write)
		else $error("first select not written");

	property p_second_select_write;
		@(posedge ref_clk) disable iff (!arst_n)
		(regWrite && regAddr == SECOND_CFG_ADDR && st.mode == CFG_RUN)
			|=> st.secondSel == $past(regWdata[SEL_MSB:SEL_LSB]);
	endproperty
	a_second_select_write: assert property (p_second_select_write)
		else $error("second select not written");

	property p_reserved_read_zero;
		@(posedge ref_clk) disable iff (!arst_n)
		1'b1 |-> regRdata[2:0] == 3'h0;
	endproperty
	a_reserved_read_zero: assert property (p_reserved_read_zero)
		else $error("reserved bits read nonzero");

	property p_read_back;
		@(posedge ref_clk) disable iff (!arst_n)
		(regRead && regAddr == SECOND_CFG_ADDR)
			|=> regRdata == {$past(st.secondSel), $past(st.secondPol), 3'h0};
	endproperty
	a_read_back: assert property (p_read_back)
		else $error("second register read mismatch");

	property p_first_read_back;
		@(posedge ref_clk) disable iff (!arst_n)
		(regRead && regAddr == FIRST_CFG_ADDR)
			|=> regRdata == {$past(st.firstSel), $past(st.firstPol), 3'h0};
	endproperty
	a_first_read_back: assert property (p_first_read_back)
		else $error("first register read mismatch");

	// the load cycle wins over any write that lands in it
	sequence s_load_cycle;
		st.mode == CFG_NVM_LOAD;
	endsequence

	property p_nvm_load;
		@(posedge ref_clk) disable iff (!arst_n)
		s_load_cycle |=>
			{st.firstSel, st.firstPol} == $past(nvmFirstCfg[SEL_MSB:POL_BIT])
			&& {st.secondSel, st.secondPol}
				== $past(nvmSecondCfg[SEL_MSB:POL_BIT]);
	endproperty
	a_nvm_load: assert property (p_nvm_load)
		else $error("memory load did not set the fields");

	property p_first_pin_mux;
		@(posedge ref_clk) disable iff (!arst_n)
		!testFirstActive |=>
			first_indicator_pin == ($past(sources[st.firstSel]) ~^ $past(st.firstPol));
	endproperty
	a_first_pin_mux: assert property (p_first_pin_mux)
		else $error("first pin does not follow source");

	property p_second_pin_mux;
		@(posedge ref_clk) disable iff (!arst_n)
		!testSecondActive |=>
			second_indicator_pin == ($past(sources[st.secondSel]) ~^ $past(st.secondPol));
	endproperty
	a_second_pin_mux: assert property (p_second_pin_mux)
		else $error("second pin does not follow source");

	property p_test_override;
		@(posedge ref_clk) disable iff (!arst_n)
		testFirstActive |=> first_indicator_pin == $past(testFirstLevel);
	endproperty
	a_test_override: assert property (p_test_override)
		else $error("test override lost");

	property p_test_override_two;
		@(posedge ref_clk) disable iff (!arst_n)
		testSecondActive |=> second_indicator_pin == $past(testSecondLevel);
	endproperty
	a_test_override_two: assert property (p_test_override_two)
		else $error("second test override lost");

	property p_interrupt_source;
		@(posedge ref_clk) disable iff (!arst_n)
		(!testFirstActive && st.firstSel == SRC_INTERRUPT)
			|=> first_indicator_pin == ($past(|(interruptFlags & interruptMask))
				~^ $past(st.firstPol));
	endproperty
	a_interrupt_source: assert property (p_interrupt_source)
		else $error("interrupt source wrong");
endmodule
`default_nettype wire

// ===== testbench/pin_monitor.sv
// board monitor that latches both status pins and counts their edges
`timescale 1ns/1ps
`default_nettype none
module pin_monitor (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       firstPin,
	input  wire logic       secondPin,
	output logic            firstSeen,
	output logic            secondSeen,
	output logic [7:0]      edgeCount
);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			firstSeen  <= 1'b0;
			secondSeen <= 1'b0;
			edgeCount  <= 8'h00;
		end else begin
			firstSeen  <= firstPin;
			secondSeen <= secondPin;
			edgeCount  <= edgeCount + {7'h00, firstPin ^ firstSeen}
				+ {7'h00, secondPin ^ secondSeen};
		end
	end
endmodule
`default_nettype wire

// ===== testbench/status_pin_source_mux_tb.sv
// self-checking bench for the status pin source selection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin \
	nCompared++; \
	if ((e) !== (s)) begin \
		nErrors++; \
		$display("wrong value %s expected %h seen %h", n, e, s); \
	end \
end
module status_pin_source_mux_tb
	import status_mux_pkg::*;
;
	// level sources, halved dividers and bypassable dividers in code order
	localparam logic [15:0] LVL = 16'he327;
	localparam logic [15:0] DIV = 16'h18d8;
	localparam logic [15:0] BYP = 16'h1848;
	logic        ref_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [7:0]  regWdata = 8'h00;
	logic        regWrite = 1'b0;
	logic        regRead = 1'b0;
	logic        nvmLoad = 1'b0;
	logic [7:0]  nvmFirstCfg = 8'h00;
	logic [7:0]  nvmSecondCfg = 8'h00;
	logic [7:0]  fl = 8'h00;
	logic [7:0]  mk = 8'h00;
	logic [15:0] lv = 16'h0000;
	logic [15:0] pv = 16'h0000;
	logic [15:0] bp = 16'h0000;
	logic [3:0]  tv = 4'h0;
	logic [15:0] half, b, m, ev;
	logic [3:0]  sa, sb;
	logic [1:0]  p;
	logic [7:0]  regRdata, edges, e0;
	logic        pinA, pinB, seenA, seenB;
	int          nErrors = 0;
	int          nCompared = 0;

	initial forever #12.5 ref_clk = ~ref_clk;

	status_pin_source_mux status_pin_source_mux_i (
		.ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .nvmLoad(nvmLoad),
		.nvmFirstCfg(nvmFirstCfg), .nvmSecondCfg(nvmSecondCfg),
		.primaryRefLos(lv[0]), .secondaryRefLos(lv[1]),
		.synthOneLol(lv[2]), .synthTwoLol(lv[5]),
		.synthOneRdivPulse(pv[3]), .synthTwoRdivPulse(pv[6]),
		.synthOneRdivBypass(bp[3]), .synthTwoRdivBypass(bp[6]),
		.synthOneNdivPulse(pv[4]), .synthTwoNdivPulse(pv[7]),
		.synthOneMdivPulse(pv[11]), .synthTwoMdivPulse(pv[12]),
		.synthOneMdivBypass(bp[11]), .synthTwoMdivBypass(bp[12]),
		.synthOneCal(lv[8]), .synthTwoCal(lv[9]), .nvmActive(lv[13]),
		.interruptFlags(fl), .interruptMask(mk),
		.synthOneAutoSwitch(lv[14]), .synthTwoAutoSwitch(lv[15]),
		.testFirstActive(tv[0]), .testFirstLevel(tv[1]),
		.testSecondActive(tv[2]), .testSecondLevel(tv[3]),
		.first_indicator_pin(pinA), .second_indicator_pin(pinB)
	);

	pin_monitor pin_monitor_i (
		.ref_clk(ref_clk), .arst_n(arst_n), .firstPin(pinA),
		.secondPin(pinB), .firstSeen(seenA), .secondSeen(seenB),
		.edgeCount(edges)
	);

	task automatic wrapUp;
		if (nErrors == 0 && nCompared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		regWrite <= 1'b1;
		regAddr  <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe, zero after it
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge ref_clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1;
		`CHK("regRdata", e, regRdata)
		@(posedge ref_clk);
		#1;
		`CHK("regRdata idle", 8'h00, regRdata)
	endtask

	// pins must have settled and then stand without any edge
	task automatic pins(input logic ea, input logic eb);
		repeat (4) @(posedge ref_clk);
		#1;
		e0 = edges;
		repeat (2) @(posedge ref_clk);
		#1;
		`CHK("first pin", ea, seenA)
		`CHK("second pin", eb, seenB)
		`CHK("pin edges", e0, edges)
	endtask

	task automatic doReset;
		arst_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		half = 16'h0000;
		rd(FIRST_CFG_ADDR, 8'h58);
		rd(SECOND_CFG_ADDR, 8'h28);
		rd(8'h00, 8'h00);
		pins(lv[5], lv[2]);
	endtask

	initial begin
		repeat (20000) @(posedge ref_clk);
		nErrors++;
		wrapUp();
	end

	initial begin
		void'($urandom(32'hc2f7));
		doReset();
		for (int c = 0; c < 16; c++) begin
			p  = 2'($urandom);
			sa = 4'(c);
			sb = ~sa;
			wr(FIRST_CFG_ADDR, {sa, p[0], 3'($urandom)});
			wr(SECOND_CFG_ADDR, {sb, p[1], 3'($urandom)});
			wr(8'h1d, 8'($urandom));
			rd(FIRST_CFG_ADDR, {sa, p[0], 3'b000});
			rd(SECOND_CFG_ADDR, {sb, p[1], 3'b000});
			b = 16'($urandom) & BYP;
			m = 16'($urandom) & DIV;
			@(posedge ref_clk);
			lv <= 16'($urandom) & LVL;
			fl <= 8'($urandom);
			mk <= 8'($urandom);
			bp <= b;
			half &= ~b;
			@(posedge ref_clk);
			pv <= m;
			@(posedge ref_clk);
			pv <= 16'h0000;
			half ^= m & ~b;
			ev = (lv & LVL) | (half & DIV) | {5'h00, |(fl & mk), 10'h000};
			pins(ev[sa] ~^ p[0], ev[sb] ~^ p[1]);
		end
		for (int t = 0; t < 4; t++) begin
			@(posedge ref_clk);
			tv <= {t[1], 1'b1, t[0], 1'b1};
			pins(t[0], t[1]);
		end
		@(posedge ref_clk);
		tv <= 4'h0;
		nvmFirstCfg  <= 8'($urandom);
		nvmSecondCfg <= 8'($urandom);
		nvmLoad <= 1'b1;
		@(posedge ref_clk);
		nvmLoad  <= 1'b0;
		// a write in the load cycle must be refused
		regWrite <= 1'b1;
		regAddr  <= FIRST_CFG_ADDR;
		regWdata <= ~nvmFirstCfg;
		@(posedge ref_clk);
		regWrite <= 1'b0;
		rd(FIRST_CFG_ADDR, nvmFirstCfg & 8'hf8);
		rd(SECOND_CFG_ADDR, nvmSecondCfg & 8'hf8);
		@(posedge ref_clk);
		doReset();
		wrapUp();
	end
endmodule
`default_nettype wire
